// ---- shared/fmc_cfg.svh ----
// Summary of operation
// - user-mode register access errors, changes nothing
// - reserved fields ignore writes, read zero
// - unimplemented offsets error with no effect
// - upper words banked by bank select
// - bank decode follows configured array size
// - freeze enable gates local-bus debug request
// - debug can clear lock, divider low bits writable
// - freeze, irq enables, bank select always writable
// - emulation writable unlocked; emulation suppresses read termination
// - emulation array write raises access error
// - lock sets once in user mode
// - lock blocks emulation and protection-type writes
// - buffer-empty enable requests irq on flag
// - completion enable requests irq on flag
// - key-write enable writable only with backdoor
// - key-write steers array writes to key path
// - divider low bits write once; bit7 read-only
// - divider byte sets timing tick rate
// - divider loaded reads one after write
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define FMC_ADDR_CFG      32'h00d0_0000
`define FMC_ADDR_TEST     32'h00d0_0004
`define FMC_ADDR_SEC      32'h00d0_0008
`define FMC_ADDR_MON      32'h00d0_000c
`define FMC_ADDR_PROT     32'h00d0_0010
`define FMC_ADDR_ACCESS   32'h00d0_0014
`define FMC_ADDR_TSTAT    32'h00d0_0018
`define FMC_ADDR_USTAT    32'h00d0_001c
`define FMC_ADDR_CMD      32'h00d0_0020
`define FMC_ADDR_CTL      32'h00d0_0024
`define FMC_ADDR_DATA     32'h00d0_0028
`define FMC_ADDR_UNIMP_LO 32'h00d0_002c
`define FMC_ADDR_UNIMP_HI 32'h00d0_003c
`define FMC_WIN_LSB       6

// ----------------------------------------------------------------
// module_configuration field positions (within its 16 bits)
// ----------------------------------------------------------------
`define FMC_CFG_FRZ       14
`define FMC_CFG_EME       12
`define FMC_CFG_LOCK      10
`define FMC_CFG_BEIE      7
`define FMC_CFG_COMPLETION_IRQ_ENABLE      6
`define FMC_CFG_KEYW      5
`define FMC_CFG_BANK_SELECT_HI  1
`define FMC_CFG_BANK_SELECT_LO  0

// ----------------------------------------------------------------
// timing_clock_divider fields and security fields
// ----------------------------------------------------------------
`define FMC_DIV_LOADED    7
`define FMC_DIV_PRE8      6
`define FMC_DIV_HI        5
`define FMC_PRE8_MAX      3'h7
`define FMC_SEC_BACKDOOR  31

`endif

// ---- shared/fmc_pkg.sv ----
package fmc_pkg;
  // array size, sets which register banks the bank select reaches
  typedef enum logic [1:0] {
    FMC_SIZE_128K,
    FMC_SIZE_256K,
    FMC_SIZE_384K,
    FMC_SIZE_512K
  } fmc_size_e;

  // operating mode seen by the write qualifiers
  typedef enum logic [1:0] {
    FMC_MODE_USER,
    FMC_MODE_DEBUG,
    FMC_MODE_TEST
  } fmc_mode_e;

  typedef logic [1:0] fmc_bank_t;
endpackage

// ---- shared/fmc_bank_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries banked protection/access register traffic
interface fmc_bank_if;
  import fmc_pkg::*;
  fmc_bank_t   bankIdx;
  logic        wrProt;
  logic        wrSacc;
  logic        wrDacc;
  logic        locked;
  logic [31:0] wdata;
  logic [15:0] rdProt;
  logic [15:0] rdSacc;
  logic [15:0] rdDacc;

  modport regs (output bankIdx, wrProt, wrSacc, wrDacc, locked, wdata,
                input  rdProt, rdSacc, rdDacc);
  modport bank (input  bankIdx, wrProt, wrSacc, wrDacc, locked, wdata,
                output rdProt, rdSacc, rdDacc);
endinterface
`default_nettype wire

// ---- rtl/fmc_bank_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmc_bank_regs #(
  parameter int NUM_BANKS = 4
) (
  input  wire logic   core_clk,
  input  wire logic   rstn,
  fmc_bank_if.bank    bif
);
  import fmc_pkg::*;

  logic [15:0] protQ [NUM_BANKS];
  logic [15:0] saccQ [NUM_BANKS];
  logic [15:0] daccQ [NUM_BANKS];

  // ----------------------------------------------------------------
  // one protection/access set per bank
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire hit = (int'(bif.bankIdx) == b) && !bif.locked;
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        protQ[b] <= 16'h0000;
        saccQ[b] <= 16'h0000;
        daccQ[b] <= 16'h0000;
      end else begin
        if (hit && bif.wrProt) protQ[b] <= bif.wdata[31:16];
        if (hit && bif.wrSacc) saccQ[b] <= bif.wdata[31:16];
        if (hit && bif.wrDacc) daccQ[b] <= bif.wdata[15:0];
      end
    end
  end

  // read mux on the selected bank
  assign bif.rdProt = protQ[bif.bankIdx];
  assign bif.rdSacc = saccQ[bif.bankIdx];
  assign bif.rdDacc = daccQ[bif.bankIdx];
endmodule
`default_nettype wire

// ---- rtl/fmc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fmc_cfg.svh"
module fmc_regs #(
  parameter fmc_pkg::fmc_size_e ARRAY_SIZE = fmc_pkg::FMC_SIZE_512K,
  parameter int                 NUM_BANKS  = 4
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // core local bus register port
  input  wire logic                 busReq,
  input  wire logic                 busWrite,
  input  wire logic                 busSuper,
  input  wire logic [31:0]          busAddr,
  input  wire logic [3:0]           busByteEn,
  input  wire logic [31:0]          busWdata,
  output logic [31:0]               busRdata,
  output logic                      transferAck,
  output logic                      transferErrAck,
  // mode inputs
  input  wire logic                 debugReq,
  input  wire logic                 testModePin,
  // state from the security and flash core
  input  wire logic [31:0]          securityWord,
  input  wire logic [31:0]          monitorData,
  input  wire logic [NUM_BANKS-1:0] bufferEmptyFlag,
  input  wire logic [NUM_BANKS-1:0] completionFlag,
  input  wire logic [31:0]          coreRdata,
  // banked core register pass-through
  output logic                      coreWrStb,
  output logic                      coreRdStb,
  output logic [5:0]                coreOffset,
  output fmc_pkg::fmc_bank_t        coreBank,
  output logic [31:0]               coreWdata,
  output logic [3:0]                coreByteEn,
  // array write steering
  input  wire logic                 arrayWrReq,
  output logic                      arrayReadTerm,
  output logic                      keyWriteStb,
  output logic                      cmdWriteStb,
  output logic                      accessErrSet,
  // status to the rest of the module
  output logic                      debugMode,
  output logic                      timingTick,
  output logic                      irqReq
);
  import fmc_pkg::*;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic      testSync1Q;
  logic      testSync2Q;
  fmc_mode_e mode;
  logic      freeMode;

  // test strap comes from a pin, so two flops first
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      testSync1Q <= 1'b0;
      testSync2Q <= 1'b0;
    end else begin
      testSync1Q <= testModePin;
      testSync2Q <= testSync1Q;
    end
  end

  logic frzQ;
  logic emeQ;
  logic lockQ;
  logic beieQ;
  logic ccieQ;
  logic keywQ;
  fmc_bank_t bkselQ;

  wire inDebug = frzQ && debugReq;
  assign mode = testSync2Q ? FMC_MODE_TEST :
                inDebug    ? FMC_MODE_DEBUG : FMC_MODE_USER;
  assign freeMode = (mode != FMC_MODE_USER);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire inWin    = (busAddr[31:`FMC_WIN_LSB] == `FMC_ADDR_CFG >> `FMC_WIN_LSB);
  wire [31:0] wordAddr = {busAddr[31:2], 2'b00};
  wire hitCfg   = inWin && (wordAddr == `FMC_ADDR_CFG);
  wire hitTest  = inWin && (wordAddr == `FMC_ADDR_TEST);
  wire hitSec   = inWin && (wordAddr == `FMC_ADDR_SEC);
  wire hitMon   = inWin && (wordAddr == `FMC_ADDR_MON);
  wire hitProt  = inWin && (wordAddr == `FMC_ADDR_PROT);
  wire hitAcc   = inWin && (wordAddr == `FMC_ADDR_ACCESS);
  wire hitCore  = inWin && (wordAddr >= `FMC_ADDR_TSTAT) &&
                  (wordAddr <= `FMC_ADDR_DATA);
  wire hitUnimp = inWin && (wordAddr >= `FMC_ADDR_UNIMP_LO) &&
                  (wordAddr <= `FMC_ADDR_UNIMP_HI);

  // errors: user mode, unimplemented, test register outside test mode
  wire errUser  = !busSuper;
  wire errTest  = hitTest && (mode != FMC_MODE_TEST);
  wire access_error_flag   = busReq && inWin && (errUser || hitUnimp || errTest);
  wire accOk    = busReq && inWin && !access_error_flag;
  wire wrOk     = accOk && busWrite;

  // byte lane qualified write strobes
  wire wrCfg    = wrOk && hitCfg && busByteEn[3] && busByteEn[2];
  wire wrDiv    = wrOk && hitCfg && busByteEn[1];
  wire wrTest   = wrOk && hitTest && busByteEn[3] && busByteEn[2];
  wire wrProtS  = wrOk && hitProt && busByteEn[3] && busByteEn[2];
  wire wrSaccS  = wrOk && hitAcc && busByteEn[3] && busByteEn[2];
  wire wrDaccS  = wrOk && hitAcc && busByteEn[1] && busByteEn[0];

  // ----------------------------------------------------------------
  // bank select decode
  // ----------------------------------------------------------------
  fmc_bank_t bankIdx;
  always_comb begin
    case (ARRAY_SIZE)
      FMC_SIZE_128K: bankIdx = 2'b00;
      FMC_SIZE_256K: bankIdx = {1'b0, bkselQ[0]};
      FMC_SIZE_384K: bankIdx = (bkselQ == 2'b11) ? 2'b10 : bkselQ;
      FMC_SIZE_512K: bankIdx = bkselQ;
      default:       bankIdx = 2'b00;
    endcase
  end

  // ----------------------------------------------------------------
  // module_configuration
  // ----------------------------------------------------------------
  wire [15:0] cfgW      = busWdata[31:16];
  wire        lockSetOk = freeMode || !lockQ;
  wire        lockNext  = freeMode ? cfgW[`FMC_CFG_LOCK]
                                   : (lockQ | cfgW[`FMC_CFG_LOCK]);
  wire        backdoor  = securityWord[`FMC_SEC_BACKDOOR];

  // configuration bits; emulation, lock and key-write each with its own write qualifier
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frzQ   <= 1'b0;
      emeQ   <= 1'b0;
      lockQ  <= 1'b0;
      beieQ  <= 1'b0;
      ccieQ  <= 1'b0;
      keywQ  <= 1'b0;
      bkselQ <= 2'b00;
    end else if (wrCfg) begin
      frzQ   <= cfgW[`FMC_CFG_FRZ];
      beieQ  <= cfgW[`FMC_CFG_BEIE];
      ccieQ  <= cfgW[`FMC_CFG_COMPLETION_IRQ_ENABLE];
      bkselQ <= cfgW[`FMC_CFG_BANK_SELECT_HI:`FMC_CFG_BANK_SELECT_LO];
      if (!lockQ) emeQ <= cfgW[`FMC_CFG_EME];
      if (lockSetOk) lockQ <= lockNext;
      if (backdoor) keywQ <= cfgW[`FMC_CFG_KEYW];
    end
  end

  wire [15:0] cfgRd = 16'((32'(frzQ)   << `FMC_CFG_FRZ)  |
                          (32'(emeQ)   << `FMC_CFG_EME)  |
                          (32'(lockQ)  << `FMC_CFG_LOCK) |
                          (32'(beieQ)  << `FMC_CFG_BEIE) |
                          (32'(ccieQ)  << `FMC_CFG_COMPLETION_IRQ_ENABLE) |
                          (32'(keywQ)  << `FMC_CFG_KEYW) |
                          32'(bkselQ));

  // ----------------------------------------------------------------
  // timing_clock_divider, low bits write-once in user mode
  // ----------------------------------------------------------------
  logic       divLoadedQ;
  logic [6:0] divQ;
  wire        divWrOk = wrDiv && (freeMode || !divLoadedQ);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divLoadedQ <= 1'b0;
      divQ       <= 7'h00;
    end else if (divWrOk) begin
      divLoadedQ <= 1'b1;
      divQ       <= busWdata[14:8];
    end
  end

  wire [7:0] divRd = {divLoadedQ, divQ};

  // ----------------------------------------------------------------
  // derived timing tick: clock / (8 if prescaled) / (div + 1)
  // ----------------------------------------------------------------
  logic [2:0] preCntQ;
  logic [5:0] divCntQ;
  logic       tickQ;
  wire        preDone = !divQ[`FMC_DIV_PRE8] || (preCntQ == `FMC_PRE8_MAX);
  wire        divDone = preDone && (divCntQ == divQ[`FMC_DIV_HI:0]);

  // counters restart while the divider has never been loaded
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      preCntQ <= 3'h0;
      divCntQ <= 6'h00;
      tickQ   <= 1'b0;
    end else begin
      preCntQ <= (preDone || !divLoadedQ) ? 3'h0 : preCntQ + 3'h1;
      if (!divLoadedQ || divDone) divCntQ <= 6'h00;
      else if (preDone) divCntQ <= divCntQ + 6'h01;
      tickQ   <= divLoadedQ && divDone;
    end
  end

  // ----------------------------------------------------------------
  // factory test register, reachable in test mode only
  // ----------------------------------------------------------------
  logic [15:0] testQ;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) testQ <= 16'h0000;
    else if (wrTest) testQ <= busWdata[31:16];
  end

  // ----------------------------------------------------------------
  // banked protection and access registers
  // ----------------------------------------------------------------
  fmc_bank_if bif ();
  assign bif.bankIdx = bankIdx;
  assign bif.locked  = lockQ;
  assign bif.wrProt  = wrProtS;
  assign bif.wrSacc  = wrSaccS;
  assign bif.wrDacc  = wrDaccS;
  assign bif.wdata   = busWdata;

  fmc_bank_regs #(
    .NUM_BANKS (NUM_BANKS)
  ) u_bank (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bif      (bif)
  );

  // ----------------------------------------------------------------
  // read data selection, reserved fields read zero
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCfg)  rdMux = {cfgRd, divRd, 8'h00};
    if (hitTest) rdMux = {testQ, 16'h0000};
    if (hitSec)  rdMux = securityWord;
    if (hitMon)  rdMux = monitorData;
    if (hitProt) rdMux = {bif.rdProt, 16'h0000};
    if (hitAcc)  rdMux = {bif.rdSacc, bif.rdDacc};
    if (hitCore) rdMux = coreRdata;
  end

  // ----------------------------------------------------------------
  // bus answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      transferAck    <= 1'b0;
      transferErrAck <= 1'b0;
      busRdata       <= 32'h0000_0000;
    end else begin
      transferAck    <= accOk;
      transferErrAck <= access_error_flag;
      busRdata       <= (accOk && !busWrite) ? rdMux : 32'h0000_0000;
    end
  end

  // banked core registers forwarded with the decoded bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      coreWrStb  <= 1'b0;
      coreRdStb  <= 1'b0;
      coreOffset <= 6'h00;
      coreBank   <= 2'b00;
      coreWdata  <= 32'h0000_0000;
      coreByteEn <= 4'h0;
    end else begin
      coreWrStb  <= accOk && hitCore && busWrite;
      coreRdStb  <= accOk && hitCore && !busWrite;
      coreOffset <= busAddr[`FMC_WIN_LSB-1:0];
      coreBank   <= bankIdx;
      coreWdata  <= busWdata;
      coreByteEn <= busByteEn;
    end
  end

  // ----------------------------------------------------------------
  // array write steering, emulation and interrupt request
  // ----------------------------------------------------------------
  wire flagEmpty = bufferEmptyFlag[bankIdx];
  wire flagDone  = completionFlag[bankIdx];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      arrayReadTerm <= 1'b1;
      keyWriteStb   <= 1'b0;
      cmdWriteStb   <= 1'b0;
      accessErrSet  <= 1'b0;
      debugMode     <= 1'b0;
      timingTick    <= 1'b0;
      irqReq        <= 1'b0;
    end else begin
      arrayReadTerm <= !emeQ;
      accessErrSet  <= arrayWrReq && emeQ;
      keyWriteStb   <= arrayWrReq && !emeQ && keywQ;
      cmdWriteStb   <= arrayWrReq && !emeQ && !keywQ;
      debugMode     <= inDebug;
      timingTick    <= tickQ;
      irqReq        <= (beieQ && flagEmpty) ||
                       (ccieQ && flagDone);
    end
  end
endmodule
`default_nettype wire

// ---- tb/fmc_regs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmc_regs_checker #(
  parameter int NUM_BANKS = 4
) (
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic                 busReq,
  input wire logic                 busWrite,
  input wire logic                 busSuper,
  input wire logic [31:0]          busAddr,
  input wire logic                 transferAck,
  input wire logic                 transferErrAck,
  input wire logic [NUM_BANKS-1:0] bufferEmptyFlag,
  input wire logic [NUM_BANKS-1:0] completionFlag,
  input wire logic                 coreRdStb,
  input wire logic                 arrayWrReq,
  input wire logic                 arrayReadTerm,
  input wire logic                 keyWriteStb,
  input wire logic                 cmdWriteStb,
  input wire logic                 accessErrSet,
  input wire logic                 irqReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // request decode inside the register window
  wire logic inWin  = busReq && busAddr[31:6] == 26'h0003_4000;
  wire logic unimp  = inWin && busAddr[5:2] >= 4'hb;
  wire logic coreAt = inWin && busAddr[5:2] >= 4'h6 && busAddr[5:2] <= 4'ha;
  wire logic arrOut = accessErrSet | keyWriteStb | cmdWriteStb;
  property p_user_err;
    inWin && !busSuper |=> transferErrAck && !transferAck;
  endproperty
  a_user_err: assert property (p_user_err) else $error("user access not refused");
  property p_unimp_err;
    unimp |=> transferErrAck && !transferAck;
  endproperty
  a_unimp_err: assert property (p_unimp_err) else $error("hole not refused");
  property p_ack_cause;
    transferAck |-> $past(inWin && busSuper);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_emu_err;
    arrayWrReq |=> accessErrSet != arrayReadTerm;
  endproperty
  a_emu_err: assert property (p_emu_err) else $error("emulation write not flagged");
  property p_steer;
    arrayWrReq |=> $onehot({accessErrSet, keyWriteStb, cmdWriteStb});
  endproperty
  a_steer: assert property (p_steer) else $error("array write not steered once");
  property p_no_spont;
    arrOut |-> $past(arrayWrReq);
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("array strobe without write");
  property p_irq_off;
    bufferEmptyFlag == '0 && completionFlag == '0 |=> !irqReq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without flag");
  property p_core_rd;
    coreAt && busSuper && !busWrite |=> coreRdStb;
  endproperty
  a_core_rd: assert property (p_core_rd) else $error("banked read not forwarded");
  // main scenarios reached
  c_err: cover property (transferErrAck);
  c_emu: cover property (arrayWrReq && !arrayReadTerm);
  c_irq: cover property (irqReq);
endmodule
bind fmc_regs fmc_regs_checker #(.NUM_BANKS(NUM_BANKS)) chk_u (
  .core_clk(core_clk), .rstn(rstn), .busReq(busReq), .busWrite(busWrite),
  .busSuper(busSuper), .busAddr(busAddr), .transferAck(transferAck),
  .transferErrAck(transferErrAck), .bufferEmptyFlag(bufferEmptyFlag),
  .completionFlag(completionFlag), .coreRdStb(coreRdStb), .arrayWrReq(arrayWrReq),
  .arrayReadTerm(arrayReadTerm), .keyWriteStb(keyWriteStb), .cmdWriteStb(cmdWriteStb),
  .accessErrSet(accessErrSet), .irqReq(irqReq));
`default_nettype wire

// ---- tb/fmc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmc_host_model (
  input  wire logic        core_clk,
  output logic             busReq,
  output logic             busWrite,
  output logic             busSuper,
  output logic [31:0]      busAddr,
  output logic [3:0]       busByteEn,
  output logic [31:0]      busWdata,
  input  wire logic [31:0] busRdata,
  input  wire logic        transferAck,
  input  wire logic        transferErrAck
);
  // idle bus at time zero
  initial begin
    busReq = 1'b0;
    busWrite = 1'b0;
    busSuper = 1'b0;
    busAddr = 32'h0000_0000;
    busByteEn = 4'h0;
    busWdata = 32'h0000_0000;
  end
  // one-cycle request, answer taken once the taking edge has settled
  task automatic acc(input logic wr, input logic sup, input logic [31:0] adr,
                     input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [1:0] ans);
    @(posedge core_clk);
    busReq <= 1'b1;
    busWrite <= wr;
    busSuper <= sup;
    busAddr <= adr;
    busByteEn <= be;
    busWdata <= wd;
    @(posedge core_clk);
    busReq <= 1'b0;
    busAddr <= ~adr;
    busWdata <= ~wd;
    #1 rd = busRdata;
    ans = {transferErrAck, transferAck};
  endtask
endmodule
`default_nettype wire

// ---- tb/test_fmc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fmc_cfg.svh"
module test_fmc_regs;
  import fmc_pkg::*;
  logic        core_clk, rstn, busReq, busWrite, busSuper, transferAck, transferErrAck;
  logic        debugReq, testModePin, arrayWrReq, coreWrStb, coreRdStb, arrayReadTerm;
  logic        keyWriteStb, cmdWriteStb, accessErrSet, debugMode, timingTick, irqReq;
  logic [31:0] busAddr, busWdata, busRdata, securityWord, monitorData, coreRdata, coreWdata;
  logic [31:0] rdv;
  logic [3:0]  busByteEn, coreByteEn, bufferEmptyFlag, completionFlag;
  logic [5:0]  coreOffset;
  logic [2:0]  arrAns;
  logic [1:0]  ans;
  fmc_bank_t   coreBank;
  int          numErrors, checks, n, b;
  fmc_regs #(.ARRAY_SIZE(FMC_SIZE_384K)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .busReq(busReq), .busWrite(busWrite),
    .busSuper(busSuper), .busAddr(busAddr), .busByteEn(busByteEn), .busWdata(busWdata),
    .busRdata(busRdata), .transferAck(transferAck), .transferErrAck(transferErrAck),
    .debugReq(debugReq), .testModePin(testModePin), .securityWord(securityWord),
    .monitorData(monitorData), .bufferEmptyFlag(bufferEmptyFlag),
    .completionFlag(completionFlag), .coreRdata(coreRdata), .coreWrStb(coreWrStb),
    .coreRdStb(coreRdStb), .coreOffset(coreOffset), .coreBank(coreBank),
    .coreWdata(coreWdata), .coreByteEn(coreByteEn), .arrayWrReq(arrayWrReq),
    .arrayReadTerm(arrayReadTerm), .keyWriteStb(keyWriteStb), .cmdWriteStb(cmdWriteStb),
    .accessErrSet(accessErrSet), .debugMode(debugMode), .timingTick(timingTick),
    .irqReq(irqReq));
  fmc_host_model host_u (
    .core_clk(core_clk), .busReq(busReq), .busWrite(busWrite), .busSuper(busSuper),
    .busAddr(busAddr), .busByteEn(busByteEn), .busWdata(busWdata), .busRdata(busRdata),
    .transferAck(transferAck), .transferErrAck(transferErrAck));
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [31:0] adr, input logic [3:0] be, input logic [31:0] d);
    host_u.acc(1'b1, 1'b1, adr, be, d, rdv, ans);
  endtask
  task automatic rd(input logic [31:0] adr);
    host_u.acc(1'b0, 1'b1, adr, 4'hf, 32'h0000_0000, rdv, ans);
  endtask
  task automatic wcfg(input logic [15:0] v);
    wr(`FMC_ADDR_CFG, 4'hc, {v, 16'h0000});
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // one array write pulse, strobes taken a cycle later
  task automatic arr;
    @(posedge core_clk);
    arrayWrReq <= 1'b1;
    @(posedge core_clk);
    arrayWrReq <= 1'b0;
    #1 arrAns = {accessErrSet, keyWriteStb, cmdWriteStb};
  endtask
  task automatic t_user;
    rd(`FMC_ADDR_CFG);
    chk("cfg at reset", rdv, 32'h0000_0000);
    host_u.acc(1'b1, 1'b0, `FMC_ADDR_CFG, 4'hc, 32'h4000_0000, rdv, ans);
    chk("user answer", 32'(ans), 32'h2);
    rd(`FMC_ADDR_CFG);
    chk("user no effect", rdv, 32'h0000_0000);
    for (int a = 'h2c; a <= 'h3c; a += 4) begin
      wr(32'h00d0_0000 + a, 4'hf, 32'hffff_ffff);
      chk("hole write", 32'(ans), 32'h2);
      rd(32'h00d0_0000 + a);
      chk("hole read", 32'(ans), 32'h2);
    end
    wr(`FMC_ADDR_CFG, 4'h1, 32'h0000_00ff);
    rd(`FMC_ADDR_CFG);
    chk("reserved byte", rdv, 32'h0000_0000);
    $display("user test done");
  endtask
  task automatic t_div;
    wr(`FMC_ADDR_CFG, 4'h2, 32'h0000_0500);
    rd(`FMC_ADDR_CFG);
    chk("divider loaded", rdv, 32'h0000_8500);
    wr(`FMC_ADDR_CFG, 4'h2, 32'h0000_8a00);
    rd(`FMC_ADDR_CFG);
    chk("divider once", rdv, 32'h0000_8500);
    repeat (2) begin
      n = 0;
      do begin @(negedge core_clk); n++; end while (!timingTick && n < 50);
    end
    chk("tick period", n, 32'd6);
    $display("divider test done");
  endtask
  task automatic t_cfg;
    @(posedge core_clk);
    securityWord <= 32'h0000_0000;
    wcfg(16'h40e3);
    rd(`FMC_ADDR_CFG);
    chk("cfg fields", rdv, 32'h40c3_8500);
    @(posedge core_clk);
    securityWord <= 32'h8000_0000;
    wcfg(16'h40e3);
    rd(`FMC_ADDR_CFG);
    chk("key write", rdv, 32'h40e3_8500);
    $display("config test done");
  endtask
  task automatic t_bank;
    for (int s = 0; s < 4; s++) begin
      wcfg({14'h0, 2'(s)});
      wr(`FMC_ADDR_PROT, 4'hf, {{4{4'(s + 1)}}, 16'hffff});
    end
    for (int s = 0; s < 4; s++) begin
      b = (s == 3) ? 2 : s; // the smaller array folds select 3 onto bank 2
      wcfg({14'h0, 2'(s)});
      rd(`FMC_ADDR_PROT);
      chk("banked prot", rdv, {{4{4'((b == 2 ? 3 : b) + 1)}}, 16'h0000});
      rd(`FMC_ADDR_TSTAT);
      chk("core bank", 32'(coreBank), b);
    end
    wr(`FMC_ADDR_ACCESS, 4'hf, 32'h1234_5678);
    rd(`FMC_ADDR_ACCESS);
    chk("limits", rdv, 32'h1234_5678);
    $display("bank test done");
  endtask
  task automatic t_irq;
    wcfg(16'h0081);
    @(posedge core_clk);
    bufferEmptyFlag <= 4'b0001;
    settle(3);
    chk("irq other bank", 32'(irqReq), 32'h0);
    @(posedge core_clk);
    bufferEmptyFlag <= 4'b0010;
    settle(3);
    chk("irq empty", 32'(irqReq), 32'h1);
    @(posedge core_clk);
    bufferEmptyFlag <= 4'b0000;
    completionFlag <= 4'b0010;
    settle(3);
    chk("irq done masked", 32'(irqReq), 32'h0);
    wcfg(16'h0041);
    settle(3);
    chk("irq done", 32'(irqReq), 32'h1);
    wcfg(16'h0001);
    settle(3);
    chk("irq cleared", 32'(irqReq), 32'h0);
    $display("irq test done");
  endtask
  task automatic t_lock;
    wcfg(16'h0400);
    wcfg(16'h1000);
    rd(`FMC_ADDR_CFG);
    chk("lock once", rdv, 32'h0400_8500);
    wr(`FMC_ADDR_PROT, 4'hc, 32'h0000_0000);
    rd(`FMC_ADDR_PROT);
    chk("prot locked", rdv, 32'h1111_0000);
    @(posedge core_clk);
    debugReq <= 1'b1;
    wcfg(16'h4400);
    settle(2);
    chk("debug mode", 32'(debugMode), 32'h1);
    wcfg(16'h4000);
    wr(`FMC_ADDR_CFG, 4'h2, 32'h0000_0a00);
    rd(`FMC_ADDR_CFG);
    chk("debug writes", rdv, 32'h4000_8a00);
    rd(`FMC_ADDR_TEST);
    chk("test reg", 32'(ans), 32'h2);
    wcfg(16'h5000);
    rd(`FMC_ADDR_CFG);
    chk("emulation on", rdv, 32'h5000_8a00);
    chk("no read term", 32'(arrayReadTerm), 32'h0);
    arr();
    chk("emu array write", 32'(arrAns), 32'h4);
    wcfg(16'h4020);
    arr();
    chk("key path", 32'(arrAns), 32'h2);
    wcfg(16'h4000);
    arr();
    chk("command path", 32'(arrAns), 32'h1);
    wcfg(16'h0000);
    settle(2);
    chk("freeze off", 32'(debugMode), 32'h0);
    @(posedge core_clk);
    debugReq <= 1'b0;
    $display("lock test done");
  endtask
  task automatic t_rerun;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    wr(`FMC_ADDR_CFG, 4'h2, 32'h0000_0300);
    wcfg(16'h0400);
    rd(`FMC_ADDR_CFG);
    chk("after reset", rdv, 32'h0400_8300);
    $display("second reset test done");
  endtask
  // inputs at time zero, reset, then the scenarios
  initial begin
    numErrors = 0;
    checks = 0;
    rstn = 1'b0;
    debugReq = 1'b0;
    testModePin = 1'b0;
    arrayWrReq = 1'b0;
    securityWord = 32'h0000_0000;
    monitorData = 32'h0000_0000;
    coreRdata = 32'h0000_0000;
    bufferEmptyFlag = 4'h0;
    completionFlag = 4'h0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_user();
    t_div();
    t_cfg();
    t_bank();
    t_irq();
    t_lock();
    t_rerun();
    stop_test();
  end
  // the scenarios need about two hundred cycles; allow 10000 cycles (40000 ns)
  initial begin
    #40000;
    numErrors++;
    stop_test();
  end
endmodule
`default_nettype wire
